// ---- dpm_chk_monitor.sv ----
`default_nettype none
module dpm_chk (
	// Clock, reset and watched inputs
	input wire logic        i_clock,
	input wire logic        i_reset_n,
	input wire logic        i_clk_en,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic [15:0] i_temp_channel_one,
	input wire logic [15:0] i_temp_channel_two,
	input wire logic [15:0] i_temp_channel_three,
	input wire logic        i_running,
	// Watched outputs
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_overtemp_fault,
	input wire logic        o_digital_relay_output,
	input wire logic        o_load_loss,
	input wire logic        o_stop_coast,
	input wire logic        o_rt_hold,
	input wire logic        o_rt_decel,
	input wire logic        o_rt_reaccel
);
	timeunit 1ns;
	timeprecision 1ps;
	wire cold = (i_temp_channel_one == 16'h0) && (i_temp_channel_two == 16'h0)
		&& (i_temp_channel_three == 16'h0);
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);
	a_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	a_ready_setup: assert property (i_clk_en && i_psel && !i_penable |=> o_pready)
		else $error("no answer after setup");
	a_ready_cause: assert property (o_pready |-> $past(i_psel && !i_penable))
		else $error("pready without setup");
	a_err_ready: assert property (o_pslverr |-> o_pready)
		else $error("pslverr outside access");
	a_data_idle: assert property (!o_pready |-> o_prdata == 32'h0)
		else $error("read data while idle");
	// Strictly greater test: a zero reading never exceeds any threshold.
	a_cold_quiet: assert property (cold [*4] |-> !o_overtemp_fault && !o_digital_relay_output)
		else $error("temperature flag with zero readings");
	a_idle_noload: assert property (!i_running [*6] |-> !o_load_loss)
		else $error("load loss while stopped");
	a_coast_cause: assert property (o_stop_coast |-> o_overtemp_fault || o_load_loss
		|| $past(o_overtemp_fault || o_load_loss))
		else $error("coast stop without fault");
	a_rt_single: assert property ($onehot0({o_rt_hold, o_rt_decel, o_rt_reaccel}))
		else $error("two ride-through phases at once");
	cover property ($rose(o_overtemp_fault));
	cover property ($rose(o_rt_reaccel));
	cover property ($rose(o_load_loss));
endmodule // dpm_chk
`default_nettype wire

// ---- dpm_monitor.v ----
// The APB interface to the registers is this design's own decision.
`include "dpm_regs.vh"
`default_nettype none
module dpm_monitor #(
	parameter TICK_CYCLES = `DPM_TICK_NS / `DPM_CLOCK_NS
) (
	// Clock, reset and enable
	input  wire        i_clock,
	input  wire        i_reset_n,
	input  wire        i_clk_en,
	// APB slave
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [17:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output reg  [31:0] o_prdata,
	output reg         o_pready,
	output reg         o_pslverr,
	// Measurements and drive state (asynchronous)
	input  wire [15:0] i_temp_channel_one,
	input  wire [15:0] i_temp_channel_two,
	input  wire [15:0] i_temp_channel_three,
	input  wire [15:0] i_bus_voltage,
	input  wire [15:0] i_output_current,
	input  wire        i_line_ok,
	input  wire        i_frame_valid,
	input  wire        i_frame_lost,
	input  wire        i_running,
	input  wire        i_start_cmd,
	// Protection outputs
	output reg         o_overtemp_fault,
	output reg         o_digital_relay_output,
	output reg         o_frame_fault,
	output reg         o_load_loss,
	output reg         o_stop_coast,
	output reg         o_stop_decel,
	output reg         o_rt_hold,
	output reg         o_rt_decel,
	output reg         o_rt_reaccel,
	output reg         o_irq
);

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
localparam SW = 85;
wire [SW-1:0] async_in = {i_temp_channel_one, i_temp_channel_two, i_temp_channel_three,
	i_bus_voltage, i_output_current, i_line_ok, i_frame_valid, i_frame_lost,
	i_running, i_start_cmd};
reg  [SW-1:0] meta_r;
reg  [SW-1:0] sync_r;
reg           lost_d_r;
reg           valid_d_r;
reg           start_d_r;
// Multi-bit samples may be torn for one cycle; the thresholds tolerate that.
always @(posedge i_clock or negedge i_reset_n) begin
	if (!i_reset_n) begin
		meta_r    <= {SW{1'b0}};
		sync_r    <= {SW{1'b0}};
		lost_d_r  <= 1'b0;
		valid_d_r <= 1'b0;
		start_d_r <= 1'b0;
	end else if (i_clk_en) begin
		meta_r    <= async_in;
		sync_r    <= meta_r;
		lost_d_r  <= sync_r[2];
		valid_d_r <= sync_r[3];
		start_d_r <= sync_r[0];
	end
end
wire [15:0] temp_a  = sync_r[84:69];
wire [15:0] temp_b  = sync_r[68:53];
wire [15:0] temp_c  = sync_r[52:37];
wire [15:0] bus_v   = sync_r[36:21];
wire [15:0] cur     = sync_r[20:5];
wire        line_ok = sync_r[4];
wire        running = sync_r[1];
wire        lost_ev  = sync_r[2] & ~lost_d_r;
wire        valid_ev = sync_r[3] & ~valid_d_r;
wire        start_ev = sync_r[0] & ~start_d_r;

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg [15:0] fault_a_r;
reg [15:0] warn_a_r;
reg [15:0] fault_b_r;
reg [15:0] warn_b_r;
reg [15:0] fault_c_r;
reg [15:0] warn_c_r;
reg [15:0] rt_mode_r;
reg [15:0] rt_recover_r;
reg [15:0] rt_rtime_r;
reg [15:0] rt_enable_r;
reg [15:0] frame_limit_r;
reg [15:0] ll_level_r;
reg [15:0] ll_time_r;
reg [15:0] action_six_r;
reg [15:0] ll_action_r;
reg [15:0] relay_func_r;
reg [4:0]  irq_status_r;
reg [4:0]  irq_mask_r;
reg [2:0]  rt_state_r;
reg [15:0] frame_cnt_r;

wire [15:0] idx    = i_paddr[17:2];
wire        wr     = i_psel & i_penable & o_pready & i_pwrite;
wire [15:0] wd     = i_pwdata[15:0];
wire        setup  = i_psel & ~i_penable;
wire        t_ok   = wd <= `DPM_TEMP_MAX;
reg  [15:0] rd;
reg         hit;

always @* begin
	rd  = 16'h0000;
	hit = 1'b1;
	case (idx)
	`DPM_IDX_FAULT_A:     rd = fault_a_r;
	`DPM_IDX_WARN_A:      rd = warn_a_r;
	`DPM_IDX_FAULT_B:     rd = fault_b_r;
	`DPM_IDX_WARN_B:      rd = warn_b_r;
	`DPM_IDX_FAULT_C:     rd = fault_c_r;
	`DPM_IDX_WARN_C:      rd = warn_c_r;
	`DPM_IDX_RT_MODE:     rd = rt_mode_r;
	`DPM_IDX_RT_RECOVER:  rd = rt_recover_r;
	`DPM_IDX_RT_RTIME:    rd = rt_rtime_r;
	`DPM_IDX_RT_ENABLE:   rd = rt_enable_r;
	`DPM_IDX_FRAME_LIMIT: rd = frame_limit_r;
	`DPM_IDX_LL_LEVEL:    rd = ll_level_r;
	`DPM_IDX_LL_TIME:     rd = ll_time_r;
	`DPM_IDX_ACTION_SIX:  rd = action_six_r;
	`DPM_IDX_LL_ACTION:   rd = ll_action_r;
	`DPM_IDX_RELAY_FUNC:  rd = relay_func_r;
	`DPM_IDX_IRQ_STATUS:  rd = {11'h000, irq_status_r};
	`DPM_IDX_IRQ_MASK:    rd = {11'h000, irq_mask_r};
	`DPM_IDX_MONITOR:     rd = {frame_cnt_r[11:0], running, rt_state_r};
	default:              hit = 1'b0;
	endcase
end

// The answer is prepared in the setup cycle so that every bus output is a flop.
always @(posedge i_clock or negedge i_reset_n) begin
	if (!i_reset_n) begin
		o_pready  <= 1'b0;
		o_pslverr <= 1'b0;
		o_prdata  <= 32'h00000000;
	end else if (i_clk_en) begin
		o_pready  <= setup;
		o_pslverr <= setup & ~hit;
		o_prdata  <= setup ? {16'h0000, rd} : 32'h00000000;
	end
end

// Out-of-range writes are dropped and the old value stays.
always @(posedge i_clock or negedge i_reset_n) begin
	if (!i_reset_n) begin
		fault_a_r     <= `DPM_RST_FAULT;
		warn_a_r      <= `DPM_RST_WARN;
		fault_b_r     <= `DPM_RST_FAULT;
		warn_b_r      <= `DPM_RST_WARN;
		fault_c_r     <= `DPM_RST_FAULT;
		warn_c_r      <= `DPM_RST_WARN;
		rt_mode_r     <= `DPM_RST_RT_MODE;
		rt_recover_r  <= `DPM_RST_RT_RECOVER;
		rt_rtime_r    <= `DPM_RST_RT_RTIME;
		rt_enable_r   <= `DPM_RST_RT_ENABLE;
		frame_limit_r <= `DPM_RST_FRAME_LIMIT;
		ll_level_r    <= `DPM_RST_LL_LEVEL;
		ll_time_r     <= `DPM_RST_LL_TIME;
		action_six_r  <= `DPM_RST_ACTION_SIX;
		ll_action_r   <= `DPM_RST_LL_ACTION;
		relay_func_r  <= `DPM_RST_RELAY_FUNC;
		irq_mask_r    <= 5'h00;
	end else if (i_clk_en && wr) begin
		case (idx)
		`DPM_IDX_FAULT_A: if (t_ok) fault_a_r <= wd;
		`DPM_IDX_WARN_A:  if (t_ok) warn_a_r <= wd;
		`DPM_IDX_FAULT_B: if (t_ok) fault_b_r <= wd;
		`DPM_IDX_WARN_B:  if (t_ok) warn_b_r <= wd;
		`DPM_IDX_FAULT_C: if (t_ok) fault_c_r <= wd;
		`DPM_IDX_WARN_C:  if (t_ok) warn_c_r <= wd;
		`DPM_IDX_RT_MODE: if (!running && wd <= 16'h0002) rt_mode_r <= wd;
		`DPM_IDX_RT_RECOVER: begin
			if (wd >= `DPM_RECOVER_MIN && wd <= `DPM_RECOVER_MAX)
				rt_recover_r <= wd;
		end
		`DPM_IDX_RT_RTIME: if (wd <= `DPM_RTIME_MAX) rt_rtime_r <= wd;
		`DPM_IDX_RT_ENABLE: begin
			if (wd >= `DPM_ENABLE_MIN && wd <= `DPM_ENABLE_MAX)
				rt_enable_r <= wd;
		end
		`DPM_IDX_FRAME_LIMIT: begin
			if (!running && wd != 16'h0000 && wd <= `DPM_FRAME_MAX)
				frame_limit_r <= wd;
		end
		`DPM_IDX_LL_LEVEL: if (wd <= `DPM_LL_LEVEL_MAX) ll_level_r <= wd;
		`DPM_IDX_LL_TIME: begin
			if (wd >= `DPM_LL_TIME_MIN && wd <= `DPM_LL_TIME_MAX)
				ll_time_r <= wd;
		end
		`DPM_IDX_ACTION_SIX: if (!running) action_six_r <= wd;
		`DPM_IDX_LL_ACTION:  ll_action_r <= wd;
		`DPM_IDX_RELAY_FUNC: relay_func_r <= wd;
		`DPM_IDX_IRQ_MASK:   irq_mask_r <= wd[4:0];
		default: ;
		endcase
	end
end

// ----------------------------------------------------------------
// Temperature supervision
// ----------------------------------------------------------------
// Only the ones digit of each selector is decoded; the upper digits belong
// to supervision functions that live outside this block.
localparam [3:0] ACT_COAST = 4'd0;
localparam [3:0] ACT_DECEL = 4'd1;
localparam [3:0] ACT_OFF   = 4'd5;
wire [15:0] ot_digit = action_six_r % 16'd10;
wire [15:0] ll_digit = ll_action_r % 16'd10;
wire [3:0]  act_ot   = ot_digit[3:0];
wire [3:0]  act_ll   = ll_digit[3:0];
wire ot_cond = (temp_a > fault_a_r) |
	(temp_b > fault_b_r) |
	(temp_c > fault_c_r);
wire warn_cond = (temp_a > warn_a_r) |
	(temp_b > warn_b_r) |
	(temp_c > warn_c_r);
wire ot_event = ot_cond && act_ot != ACT_OFF;

// ----------------------------------------------------------------
// Timebase, frame loss and load loss
// ----------------------------------------------------------------
// One free-running 0.1 s tick serves both timers, so the first count of a
// timer may come up to one tick early; the tenths resolution hides that.
reg [31:0] tick_cnt_r;
reg [15:0] ll_cnt_r;
reg [15:0] rt_cnt_r;
wire tick = tick_cnt_r == TICK_CYCLES - 1;
wire low_cur = running && cur < ll_level_r;
wire frame_event = frame_cnt_r > frame_limit_r;
wire ll_event = ll_cnt_r > ll_time_r && act_ll != ACT_OFF;

always @(posedge i_clock or negedge i_reset_n) begin
	if (!i_reset_n) begin
		tick_cnt_r  <= 32'h00000000;
		frame_cnt_r <= 16'h0000;
		ll_cnt_r    <= 16'h0000;
	end else if (i_clk_en) begin
		tick_cnt_r <= tick ? 32'h00000000 : tick_cnt_r + 32'h00000001;
		// The frame counter saturates rather than wrapping, so a long outage
		// can never look like a short one.
		if (valid_ev)
			frame_cnt_r <= 16'h0000;
		else if (lost_ev && frame_cnt_r != 16'hffff)
			frame_cnt_r <= frame_cnt_r + 16'h0001;
		if (!low_cur)
			ll_cnt_r <= 16'h0000;
		else if (tick && ll_cnt_r != 16'hffff)
			ll_cnt_r <= ll_cnt_r + 16'h0001;
	end
end

// ----------------------------------------------------------------
// Power-dip ride-through
// ----------------------------------------------------------------
localparam RT_IDLE = 3'd0;
localparam RT_HOLD = 3'd1;
localparam RT_RISE = 3'd2;
localparam RT_WAIT = 3'd3;
localparam RT_STOP = 3'd4;
localparam RT_HALT = 3'd5;

// Bus voltage and levels are in tenths of a percent of 540 V.
wire [15:0] en_lvl  = rt_enable_r * 16'd10;
wire [15:0] rec_lvl = en_lvl + rt_recover_r;
// A dip needs both a low bus and a lost line, so a slow sag with the line
// still present is left to the undervoltage trip.
wire        dip     = running && bus_v < en_lvl && !line_ok;
reg  [2:0]  rt_nxt;

always @* begin
	rt_nxt = rt_state_r;
	case (rt_state_r)
	RT_IDLE: begin
		if (dip && rt_mode_r == 16'h0001)
			rt_nxt = RT_HOLD;
		else if (dip && rt_mode_r == 16'h0002)
			rt_nxt = RT_STOP;
	end
	RT_HOLD: if (line_ok) rt_nxt = RT_RISE;
	RT_RISE: if (bus_v >= rec_lvl) rt_nxt = RT_WAIT;
	RT_WAIT: if (rt_cnt_r >= rt_rtime_r) rt_nxt = RT_IDLE;
	RT_STOP: if (!running) rt_nxt = RT_HALT;
	RT_HALT: if (start_ev) rt_nxt = RT_IDLE;
	default: rt_nxt = RT_IDLE;
	endcase
end

always @(posedge i_clock or negedge i_reset_n) begin
	if (!i_reset_n) begin
		rt_state_r <= RT_IDLE;
		rt_cnt_r   <= 16'h0000;
	end else if (i_clk_en) begin
		rt_state_r <= rt_nxt;
		if (rt_state_r != RT_WAIT)
			rt_cnt_r <= 16'h0000;
		else if (tick)
			rt_cnt_r <= rt_cnt_r + 16'h0001;
	end
end

// ----------------------------------------------------------------
// Outputs and interrupt
// ----------------------------------------------------------------
wire [4:0] ev = {rt_state_r == RT_IDLE && rt_nxt != RT_IDLE,
	ll_event, frame_event, warn_cond, ot_event};
// Status bits are set again every cycle their cause holds, so a bit that
// software clears comes back at once while the cause persists.
wire clr_st = wr && idx == `DPM_IDX_IRQ_STATUS;
wire [4:0] st_nxt = (irq_status_r & ~(clr_st ? wd[4:0] : 5'h00)) | ev;

always @(posedge i_clock or negedge i_reset_n) begin
	if (!i_reset_n) begin
		irq_status_r           <= 5'h00;
		o_irq                  <= 1'b0;
		o_overtemp_fault       <= 1'b0;
		o_digital_relay_output <= 1'b0;
		o_frame_fault          <= 1'b0;
		o_load_loss            <= 1'b0;
		o_stop_coast           <= 1'b0;
		o_stop_decel           <= 1'b0;
		o_rt_hold              <= 1'b0;
		o_rt_decel             <= 1'b0;
		o_rt_reaccel           <= 1'b0;
	end else if (i_clk_en) begin
		irq_status_r           <= st_nxt; // Set wins over the clear.
		o_irq                  <= |(st_nxt & irq_mask_r);
		o_overtemp_fault       <= ot_event;
		o_digital_relay_output <= warn_cond && relay_func_r == `DPM_FUNC_OVERTEMP;
		o_frame_fault          <= frame_event;
		o_load_loss            <= ll_event;
		o_stop_coast <= (ot_event && act_ot == ACT_COAST) ||
			(ll_event && act_ll == ACT_COAST);
		o_stop_decel <= (ot_event && act_ot == ACT_DECEL) ||
			(ll_event && act_ll == ACT_DECEL) || rt_nxt == RT_STOP;
		o_rt_hold    <= rt_nxt == RT_HOLD;
		o_rt_decel   <= rt_nxt == RT_RISE;
		o_rt_reaccel <= rt_nxt == RT_WAIT;
	end
end

endmodule // dpm_monitor
`default_nettype wire

// ---- dpm_monitor_tb.sv ----
`include "dpm_regs.vh"
`default_nettype none
module dpm_monitor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clock   = 1'b0;
	logic        i_reset_n = 1'b0;
	logic        i_clk_en  = 1'b1;
	logic        i_psel    = 1'b0;
	logic        i_penable = 1'b0;
	logic        i_pwrite  = 1'b0;
	logic [17:0] i_paddr   = 18'h0;
	logic [31:0] i_pwdata  = 32'h0;
	wire  [31:0] o_prdata;
	wire         o_pready;
	wire         o_pslverr;
	wire  [15:0] temp_a;
	wire  [15:0] temp_b;
	wire  [15:0] temp_c;
	wire  [15:0] bus;
	wire  [15:0] cur;
	wire         line_ok;
	wire         running;
	wire  [2:0]  ev;
	wire  [9:0]  outs;
	int          fails = 0;
	int          num_checks = 0;
	logic [15:0] ridx [9] = '{`DPM_IDX_FAULT_A, `DPM_IDX_WARN_A, `DPM_IDX_FAULT_B,
		`DPM_IDX_WARN_B, `DPM_IDX_FAULT_C, `DPM_IDX_WARN_C, `DPM_IDX_RT_MODE,
		`DPM_IDX_RT_ENABLE, `DPM_IDX_FRAME_LIMIT};
	logic [15:0] rval [9] = '{16'h006e, 16'h005a, 16'h006e, 16'h005a, 16'h006e, 16'h005a,
		16'h0000, 16'h0050, 16'h000a};
	logic [15:0] acts [3] = '{16'd5501, 16'd5505, 16'd5504};
	logic [9:0]  acte [3] = '{10'h023, 10'h002, 10'h003};
	dpm_monitor #(.TICK_CYCLES(10)) dut (.i_clock, .i_reset_n, .i_clk_en, .i_psel,
		.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
		.i_temp_channel_one(temp_a), .i_temp_channel_two(temp_b),
		.i_temp_channel_three(temp_c), .i_bus_voltage(bus), .i_output_current(cur),
		.i_line_ok(line_ok), .i_frame_valid(ev[1]), .i_frame_lost(ev[0]), .i_running(running),
		.i_start_cmd(ev[2]), .o_overtemp_fault(outs[0]), .o_digital_relay_output(outs[1]),
		.o_frame_fault(outs[2]), .o_load_loss(outs[3]), .o_stop_coast(outs[4]),
		.o_stop_decel(outs[5]), .o_rt_hold(outs[6]), .o_rt_decel(outs[7]),
		.o_rt_reaccel(outs[8]), .o_irq(outs[9]));
	dpm_plant u_plant (.i_clock, .o_temp_one(temp_a), .o_temp_two(temp_b),
		.o_temp_three(temp_c), .o_bus(bus), .o_current(cur),
		.o_line_ok(line_ok), .o_running(running), .o_event(ev));
	initial forever #5 i_clock = ~i_clock;
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] wd,
		output logic [15:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge i_clock);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= {idx, 2'b00};
		i_pwdata <= {16'h0, wd};
		@(posedge i_clock);
		i_penable <= 1'b1;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_pready !== 1'b1 && n < 50);
		check("pready", 16'h1, {15'h0, o_pready});
		rd = o_prdata[15:0];
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [15:0] d);
		logic [15:0] r;
		logic        e;
		apb(1'b1, idx, d, r, e);
	endtask
	task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
		logic [15:0] r;
		logic        e;
		apb(1'b0, idx, 16'h0, r, e);
		check($sformatf("reg %h", idx), exp, r);
	endtask
	// Output bits: 0 fault, 1 relay, 2 frame, 3 load, 4 coast, 5 decel, 6-8 ride, 9 irq.
	task automatic outs_are(input int n, input logic [9:0] exp);
		repeat (n) @(posedge i_clock);
		@(negedge i_clock);
		check("outputs", {6'h0, exp}, {6'h0, outs});
	endtask
	task automatic give_verdict();
		if (fails == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_clock);
		fails++;
		$display("MISMATCH watchdog expected finish seen timeout");
		give_verdict();
	end
	initial begin
		logic [15:0] r;
		logic        e;
		repeat (20) @(posedge i_clock);
		i_reset_n <= 1'b1;
		for (int i = 0; i < 9; i++) rd(ridx[i], rval[i]);
		apb(1'b0, 16'hf900, 16'h0, r, e);
		check("unmapped error", 16'h1, {15'h0, e});
		wr(`DPM_IDX_FAULT_A, 16'd201);
		rd(`DPM_IDX_FAULT_A, 16'h006e);
		wr(`DPM_IDX_RT_MODE, 16'h0003);
		rd(`DPM_IDX_RT_MODE, 16'h0000);
		wr(`DPM_IDX_RELAY_FUNC, `DPM_FUNC_OVERTEMP);
		for (int ch = 0; ch < 3; ch++) begin
			u_plant.set_temp(ch, 16'd91);
			outs_are(6, 10'h002);
			u_plant.set_temp(ch, 16'd110);
			outs_are(6, 10'h002);
			u_plant.set_temp(ch, 16'd111);
			outs_are(6, 10'h013);
			u_plant.set_temp(ch, 16'd0);
			outs_are(6, 10'h000);
		end
		u_plant.set_temp(0, 16'd111);
		for (int i = 0; i < 3; i++) begin
			wr(`DPM_IDX_ACTION_SIX, acts[i]);
			outs_are(6, acte[i]);
		end
		wr(`DPM_IDX_IRQ_MASK, 16'h0001);
		outs_are(3, 10'h203);
		u_plant.set_temp(0, 16'd0);
		outs_are(6, 10'h200);
		wr(`DPM_IDX_IRQ_STATUS, 16'h001f);
		outs_are(3, 10'h000);
		// A low clock enable must freeze the synchronisers and every output.
		@(posedge i_clock);
		i_clk_en <= 1'b0;
		u_plant.set_temp(0, 16'd111);
		outs_are(6, 10'h000);
		@(posedge i_clock);
		i_clk_en <= 1'b1;
		outs_are(6, 10'h203);
		u_plant.set_temp(0, 16'd0);
		outs_are(6, 10'h200);
		wr(`DPM_IDX_IRQ_STATUS, 16'h001f);
		outs_are(3, 10'h000);
		wr(`DPM_IDX_IRQ_MASK, 16'h0000);
		wr(`DPM_IDX_FRAME_LIMIT, 16'h0003);
		repeat (3) u_plant.pulse(0);
		outs_are(3, 10'h000);
		u_plant.pulse(0);
		outs_are(3, 10'h004);
		u_plant.pulse(1);
		outs_are(3, 10'h000);
		wr(`DPM_IDX_LL_TIME, 16'h0002);
		u_plant.set_load(1'b1, 16'd50);
		outs_are(12, 10'h000);
		outs_are(40, 10'h018);
		wr(`DPM_IDX_LL_ACTION, 16'd5);
		outs_are(3, 10'h000);
		wr(`DPM_IDX_LL_ACTION, 16'd1);
		outs_are(3, 10'h028);
		u_plant.set_load(1'b1, 16'd500);
		outs_are(6, 10'h000);
		wr(`DPM_IDX_RT_MODE, 16'h0001);
		rd(`DPM_IDX_RT_MODE, 16'h0000);
		u_plant.set_load(1'b0, 16'd500);
		outs_are(3, 10'h000);
		wr(`DPM_IDX_RT_MODE, 16'h0001);
		u_plant.set_load(1'b1, 16'd500);
		u_plant.set_supply(16'd700, 1'b0);
		outs_are(6, 10'h040);
		u_plant.set_supply(16'd700, 1'b1);
		outs_are(6, 10'h080);
		u_plant.set_supply(16'd900, 1'b1);
		outs_are(6, 10'h100);
		outs_are(20, 10'h100);
		outs_are(50, 10'h000);
		u_plant.set_load(1'b0, 16'd500);
		outs_are(3, 10'h000);
		wr(`DPM_IDX_RT_MODE, 16'h0002);
		u_plant.set_load(1'b1, 16'd500);
		u_plant.set_supply(16'd700, 1'b0);
		outs_are(6, 10'h020);
		u_plant.set_supply(16'd1000, 1'b1);
		outs_are(6, 10'h020);
		u_plant.set_load(1'b0, 16'd500);
		repeat (4) @(posedge i_clock);
		rd(`DPM_IDX_MONITOR, 16'h0005);
		u_plant.set_load(1'b1, 16'd500);
		repeat (4) @(posedge i_clock);
		rd(`DPM_IDX_MONITOR, 16'h000d);
		u_plant.pulse(2);
		rd(`DPM_IDX_MONITOR, 16'h0008);
		give_verdict();
	end
endmodule // dpm_monitor_tb
bind dpm_monitor dpm_chk u_chk (.i_clock, .i_reset_n, .i_clk_en, .i_psel, .i_penable,
	.i_temp_channel_one, .i_temp_channel_two, .i_temp_channel_three, .i_running, .o_prdata,
	.o_pready, .o_pslverr, .o_overtemp_fault, .o_digital_relay_output, .o_load_loss,
	.o_stop_coast, .o_rt_hold, .o_rt_decel, .o_rt_reaccel);
`default_nettype wire

// ---- dpm_plant_model.sv ----
`default_nettype none
// Temperature sensors and power-stage readings feeding the monitor.
module dpm_plant (
	input  wire logic        i_clock,
	// Readings
	output var  logic [15:0] o_temp_one,
	output var  logic [15:0] o_temp_two,
	output var  logic [15:0] o_temp_three,
	output var  logic [15:0] o_bus,
	output var  logic [15:0] o_current,
	output var  logic        o_line_ok,
	output var  logic        o_running,
	// Events: 0 lost frame, 1 good frame, 2 start
	output var  logic [2:0]  o_event
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_temp_one = 16'h0;
		o_temp_two = 16'h0;
		o_temp_three = 16'h0;
		o_bus = 16'h03e8;
		o_current = 16'h0;
		o_line_ok = 1'b1;
		o_running = 1'b0;
		o_event = 3'h0;
	end
	task automatic set_temp(input int ch, input logic [15:0] v);
		@(posedge i_clock);
		case (ch)
		0: o_temp_one <= v;
		1: o_temp_two <= v;
		default: o_temp_three <= v;
		endcase
	endtask
	task automatic set_supply(input logic [15:0] bus, input logic ok);
		@(posedge i_clock);
		o_bus <= bus;
		o_line_ok <= ok;
	endtask
	task automatic set_load(input logic run, input logic [15:0] cur);
		@(posedge i_clock);
		o_running <= run;
		o_current <= cur;
	endtask
	// Held three cycles each way so the input synchroniser cannot miss an edge.
	task automatic pulse(input int n);
		@(posedge i_clock);
		o_event[n] <= 1'b1;
		repeat (3) @(posedge i_clock);
		o_event[n] <= 1'b0;
		repeat (3) @(posedge i_clock);
	endtask
endmodule // dpm_plant
`default_nettype wire

// ---- dpm_regs.vh ----
`ifndef DPM_REGS_VH
`define DPM_REGS_VH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DPM_IDX_LL_ACTION   16'hf931
`define DPM_IDX_ACTION_SIX  16'hf935
`define DPM_IDX_FAULT_A     16'hf939
`define DPM_IDX_WARN_A      16'hf93a
`define DPM_IDX_FAULT_B     16'hf93b
`define DPM_IDX_WARN_B      16'hf93c
`define DPM_IDX_FAULT_C     16'hf93d
`define DPM_IDX_WARN_C      16'hf93e
`define DPM_IDX_RT_MODE     16'hf93f
`define DPM_IDX_RT_RECOVER  16'hf940
`define DPM_IDX_RT_RTIME    16'hf941
`define DPM_IDX_RT_ENABLE   16'hf942
`define DPM_IDX_FRAME_LIMIT 16'hf943
`define DPM_IDX_LL_LEVEL    16'hf944
`define DPM_IDX_LL_TIME     16'hf945
`define DPM_IDX_RELAY_FUNC  16'hf950
`define DPM_IDX_IRQ_STATUS  16'hf951
`define DPM_IDX_IRQ_MASK    16'hf952
`define DPM_IDX_MONITOR     16'hf953
// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define DPM_RST_FAULT       16'h006e
`define DPM_RST_WARN        16'h005a
`define DPM_RST_RT_MODE     16'h0000
`define DPM_RST_RT_RECOVER  16'h0055
`define DPM_RST_RT_RTIME    16'h0005
`define DPM_RST_RT_ENABLE   16'h0050
`define DPM_RST_FRAME_LIMIT 16'h000a
`define DPM_RST_LL_LEVEL    16'h0064
`define DPM_RST_LL_TIME     16'h000a
`define DPM_RST_ACTION_SIX  16'h157c
`define DPM_RST_LL_ACTION   16'h0000
`define DPM_RST_RELAY_FUNC  16'h0000
`define DPM_TEMP_MAX        16'h00c8
`define DPM_RECOVER_MIN     16'h0050
`define DPM_RECOVER_MAX     16'h0064
`define DPM_RTIME_MAX       16'h03e8
`define DPM_ENABLE_MIN      16'h003c
`define DPM_ENABLE_MAX      16'h0064
`define DPM_FRAME_MAX       16'h03e8
`define DPM_LL_LEVEL_MAX    16'h03e8
`define DPM_LL_TIME_MIN     16'h0001
`define DPM_LL_TIME_MAX     16'h0258
`define DPM_FUNC_OVERTEMP   16'h0009
// ----------------------------------------------------------------
// Timing: one timer tick is 0.1 s
// ----------------------------------------------------------------
`define DPM_TICK_NS         100000000
`define DPM_CLOCK_NS        10
`endif
